// >>> include/mppdc_pkg.sv
// Package with register map, field positions and reset values for the pin block.
package mppdc_pkg;
  localparam int          PORT_W           = 8;
  localparam int          ADDR_W           = 6;
  localparam logic [5:0]  ADDR_OUT_PORT    = 6'h00;
  localparam logic [5:0]  ADDR_DIRS        = 6'h04;
  localparam logic [5:0]  ADDR_TRIS        = 6'h08;
  localparam logic [5:0]  ADDR_PINS        = 6'h0C;
  localparam logic [5:0]  ADDR_PORTC_ALIAS = 6'h10;
  localparam logic [5:0]  ADDR_CMD         = 6'h14;
  localparam logic [5:0]  ADDR_PERIPH      = 6'h18;
  localparam logic [5:0]  ADDR_STD_IN      = 6'h1C;
  localparam logic [5:0]  ADDR_BIDIR_IN    = 6'h20;
  localparam logic [5:0]  ADDR_ANA_IN      = 6'h24;
  localparam logic [5:0]  ADDR_TEST        = 6'h28;
  localparam logic [7:0]  RST_OUT_PORT     = 8'h00;
  localparam logic [7:0]  RST_DIRS         = 8'h00;
  localparam logic [7:0]  RST_PINS         = 8'h00;
  localparam logic [1:0]  RST_PERIPH       = 2'h0;
  localparam logic [31:0] RD_UNMAPPED      = 32'h0000_0000;
  localparam int          CMD_PIN_LSB      = 0;
  localparam int          CMD_HIGH_BIT     = 8;
  localparam int          CMD_LOW_BIT      = 9;
  localparam int          PER_PWM_BIT      = 0;
  localparam int          PER_TWI_BIT      = 1;
  localparam int          PWM_A_PIN        = 1;
  localparam int          PWM_B_PIN        = 2;
  localparam int          TWI_CLK_PIN      = 3;
  localparam int          TWI_DAT_PIN      = 4;
  localparam int          IR_PIN           = 0;
  localparam int          KBD_CLK_PIN      = 6;
  localparam int          KBD_DAT_PIN      = 7;
  localparam int          TST_MASK_LSB     = 0;
  localparam int          TST_PORT_LSB     = 8;
  localparam int          TST_ALL_BIT      = 10;
  localparam logic [1:0]  TPORT_STD        = 2'h0;
  localparam logic [1:0]  TPORT_BIDIR      = 2'h1;
  localparam logic [1:0]  TPORT_ANA        = 2'h2;
  localparam int          ANA_DIG_PINS     = 4;
  localparam int          REFRESH_CYCLES   = 64;
endpackage

// >>> logic/mppdc_top.sv
// Pin direction and data logic for the five-port device behind Avalon-MM.
`timescale 1ns/1ps
module mppdc_top #(
  parameter int REFRESH = mppdc_pkg::REFRESH_CYCLES
) (
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  input  wire logic [mppdc_pkg::ADDR_W-1:0]  avsAddress,
  input  wire logic                          avsRead,
  input  wire logic                          avsWrite,
  input  wire logic [31:0]                   avsWritedata,
  input  wire logic [3:0]                    avsByteenable,
  output logic      [31:0]                   avsReaddata,
  output logic                               avsWaitrequest,
  output logic      [7:0]                    fixedOutputPort,
  input  wire logic [7:0]                    standardInputPort,
  input  wire logic [7:0]                    bidirIn,
  output logic      [7:0]                    bidirOut,
  output logic      [7:0]                    bidirOe,
  input  wire logic [3:0]                    analogCapableIn,
  input  wire logic [2:0]                    fixedAnalogPort,
  input  wire logic                          pwmA,
  input  wire logic                          pwmB,
  output logic                               pwmSelect,
  output logic                               twoWireTargetCmd,
  output logic      [2:0]                    analogSample,
  output logic                               irIn,
  output logic                               kbdClk,
  output logic                               kbdData
);
  import mppdc_pkg::*;

  logic [7:0]  outLatch, next_outLatch;
  logic [7:0]  dirCopy, next_dirCopy;
  logic [7:0]  dirLive, next_dirLive;
  logic [7:0]  fixedData, next_fixedData;
  logic [1:0]  periph, next_periph;
  logic [15:0] refreshCnt, next_refreshCnt;
  logic [31:0] rdData, next_rdData;
  logic        waitReq, next_waitReq;
  logic [7:0]  next_bidirOut, next_bidirOe;
  logic [7:0]  testResult;
  logic [7:0]  wb;
  logic [2:0]  cmdPin;
  logic        acc;
  logic        wrAcc;
  logic        refreshDue;

  assign acc    = (avsRead | avsWrite) & waitReq;
  assign wrAcc  = acc & avsWrite & avsByteenable[0];
  assign wb     = avsWritedata[7:0];
  assign cmdPin = avsWritedata[CMD_PIN_LSB +: 3];

  // A level test picks at most one port by its select field; select value 3 picks none.
  // Analogue-capable pins offer only the plain level here.
  always_comb begin
    logic [7:0] src;
    logic [7:0] msk;
    src = 8'h00;
    msk = avsWritedata[TST_MASK_LSB +: 8];
    case (avsWritedata[TST_PORT_LSB +: 2])
      TPORT_STD:   src = standardInputPort;
      TPORT_BIDIR: src = bidirIn;
      TPORT_ANA:   src = {4'h0, analogCapableIn};
      default:     src = 8'h00;
    endcase
    if (avsWritedata[TST_ALL_BIT]) begin
      testResult = {7'h00, ((src & msk) == msk)};
    end else begin
      testResult = {7'h00, |(src & msk)};
    end
  end

  // Refresh timer of the firmware direction copy.
  // The timer runs free, so a raw poke lasts at most one period.
  always_comb begin
    next_refreshCnt = refreshCnt + 16'h0001;
    refreshDue      = 1'b0;
    // Compare with >= so the timer can never run past its period.
    if (refreshCnt >= 16'(REFRESH - 1)) begin
      next_refreshCnt = 16'h0000;
      refreshDue      = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refreshCnt <= 16'h0000;
    end else begin
      refreshCnt <= next_refreshCnt;
    end
  end

  // Direction state: the firmware copy and the live register.
  // A raw poke only reaches the live register, so the next refresh
  // undoes it; commands and the direction views update both.
  always_comb begin
    next_dirCopy = dirCopy;
    next_dirLive = dirLive;
    if (refreshDue) begin
      next_dirLive = dirCopy;
    end
    if (wrAcc) begin
      case (avsAddress)
        ADDR_DIRS: begin
          next_dirCopy = wb;
          next_dirLive = wb;
        end
        ADDR_TRIS: begin
          next_dirCopy = ~wb;
          next_dirLive = ~wb;
        end
        ADDR_BIDIR_IN: begin
          next_dirLive = wb;
        end
        ADDR_CMD: begin
          // Either command turns the pin into an output first.
          if (avsWritedata[CMD_HIGH_BIT] || avsWritedata[CMD_LOW_BIT]) begin
            next_dirCopy[cmdPin] = 1'b1;
            next_dirLive[cmdPin] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dirCopy <= RST_DIRS;
      dirLive <= RST_DIRS;
    end else begin
      dirCopy <= next_dirCopy;
      dirLive <= next_dirLive;
    end
  end

  // Data state: bidirectional latch, fixed port data and peripheral
  // selection. The latch keeps its value while a pin is an input.
  always_comb begin
    next_outLatch  = outLatch;
    next_fixedData = fixedData;
    next_periph    = periph;
    if (wrAcc) begin
      case (avsAddress)
        ADDR_OUT_PORT: begin
          // The fixed port has no direction, so every write reaches it.
          next_fixedData = wb;
        end
        ADDR_PINS,
        ADDR_PORTC_ALIAS: begin
          next_outLatch = wb;
        end
        ADDR_CMD: begin
          // Drive-high wins when both command bits are set.
          if (avsWritedata[CMD_HIGH_BIT]) begin
            next_outLatch[cmdPin] = 1'b1;
          end else if (avsWritedata[CMD_LOW_BIT]) begin
            next_outLatch[cmdPin] = 1'b0;
          end
        end
        ADDR_PERIPH: begin
          next_periph = avsWritedata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      outLatch        <= RST_PINS;
      fixedData       <= RST_OUT_PORT;
      periph          <= RST_PERIPH;
      fixedOutputPort <= RST_OUT_PORT;
    end else begin
      outLatch        <= next_outLatch;
      fixedData       <= next_fixedData;
      periph          <= next_periph;
      fixedOutputPort <= next_fixedData;
    end
  end

  // Bus answer: one wait state, then read data that holds until the next access.
  // Unmapped reads return zero; unmapped writes are ignored.
  always_comb begin
    next_waitReq = 1'b1;
    next_rdData  = rdData;
    if (acc) begin
      next_waitReq = 1'b0;
      next_rdData  = RD_UNMAPPED;
    end
    if (acc && avsRead) begin
      case (avsAddress)
        ADDR_OUT_PORT:    next_rdData = {24'h0, fixedData};
        ADDR_DIRS:        next_rdData = {24'h0, dirCopy};
        // The inverted view is read back from the copy as well.
        ADDR_TRIS:        next_rdData = {24'h0, ~dirCopy};
        ADDR_PINS,
        ADDR_PORTC_ALIAS: next_rdData = {24'h0, outLatch};
        ADDR_PERIPH:      next_rdData = {30'h0, periph};
        ADDR_STD_IN:      next_rdData = {24'h0, standardInputPort};
        ADDR_BIDIR_IN:    next_rdData = {24'h0, bidirIn};
        ADDR_ANA_IN:      next_rdData = {28'h0, analogCapableIn};
        // A test is this read alone, with its select word held on avsWritedata during the read.
        ADDR_TEST:        next_rdData = {24'h0, testResult};
        default:          next_rdData = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdData         <= RD_UNMAPPED;
      waitReq        <= 1'b1;
      avsReaddata    <= RD_UNMAPPED;
      avsWaitrequest <= 1'b1;
    end else begin
      rdData         <= next_rdData;
      waitReq        <= next_waitReq;
      avsReaddata    <= next_rdData;
      avsWaitrequest <= next_waitReq;
    end
  end

  // Peripheral selection takes pins 1..4 over from the data latch.
  // The loop index is fixed per pin, so the compares fold away.
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    logic pinOut;
    logic pinOe;
    always_comb begin
      pinOut = outLatch[i] & dirLive[i];
      pinOe  = dirLive[i];
      if (periph[PER_PWM_BIT] && i == PWM_A_PIN) begin
        pinOut = pwmA;
        pinOe  = 1'b1;
      end
      if (periph[PER_PWM_BIT] && i == PWM_B_PIN) begin
        pinOut = pwmB;
        pinOe  = 1'b1;
      end
      // Two-wire pins are inputs to the target engine, so release them.
      if (periph[PER_TWI_BIT]
          && (i == TWI_CLK_PIN || i == TWI_DAT_PIN)) begin
        pinOut = 1'b0;
        pinOe  = 1'b0;
      end
    end
    assign next_bidirOut[i] = pinOut;
    assign next_bidirOe[i]  = pinOe;
  end

  // Pin drivers are registered so that every output comes from a flop.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bidirOut         <= 8'h00;
      bidirOe          <= 8'h00;
      pwmSelect        <= 1'b0;
      twoWireTargetCmd <= 1'b0;
    end else begin
      bidirOut         <= next_bidirOut;
      bidirOe          <= next_bidirOe;
      pwmSelect        <= next_periph[PER_PWM_BIT];
      twoWireTargetCmd <= next_periph[PER_TWI_BIT];
    end
  end

  // Input copies: the fixed analogue port only feeds analogSample and has no bus read.
  // Keyboard and infrared lines are plain copies of the input port.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      analogSample <= 3'h0;
      irIn         <= 1'b0;
      kbdClk       <= 1'b0;
      kbdData      <= 1'b0;
    end else begin
      analogSample <= fixedAnalogPort;
      irIn         <= standardInputPort[IR_PIN];
      kbdClk       <= standardInputPort[KBD_CLK_PIN];
      kbdData      <= standardInputPort[KBD_DAT_PIN];
    end
  end
endmodule

// >>> tb/mppdc_assertions.sv
// Checker of bus timing and pin driving for the pin block.
`timescale 1ns/1ps
module mppdc_assertions
  import mppdc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [5:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0]  avsByteenable,
  input wire logic [31:0] avsReaddata,
  input wire logic        avsWaitrequest,
  input wire logic [7:0]  fixedOutputPort,
  input wire logic [7:0]  bidirOut,
  input wire logic [7:0]  bidirOe,
  input wire logic        pwmSelect,
  input wire logic        twoWireTargetCmd
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic       wEff;
  logic       plain;
  logic       cmdW;
  logic [2:0] pin;
  // Peripheral routing overrides the latch, so pin checks skip it.
  assign plain = !pwmSelect && !twoWireTargetCmd;
  assign wEff = avsWrite && !avsWaitrequest && avsByteenable[0];
  assign cmdW = wEff && plain && avsAddress == ADDR_CMD;
  assign pin = avsWritedata[2:0];
  a_bus_answer: assert property ((avsRead || avsWrite) && avsWaitrequest
    |=> !avsWaitrequest) else $error("bus answer late");
  a_answer_once: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low too long");
  a_reset_inputs: assert property (!$past(nrst) |-> bidirOe == 8'h00)
    else $error("pins not inputs after reset");
  a_drive_high: assert property (cmdW && avsWritedata[CMD_HIGH_BIT]
    |-> ##2 bidirOe[$past(pin, 2)] && bidirOut[$past(pin, 2)])
    else $error("drive high missed");
  a_drive_low: assert property (cmdW && !avsWritedata[CMD_HIGH_BIT]
    && avsWritedata[CMD_LOW_BIT]
    |-> ##2 bidirOe[$past(pin, 2)] && !bidirOut[$past(pin, 2)])
    else $error("drive low missed");
  a_dir_write: assert property (wEff && plain && avsAddress == ADDR_DIRS
    |-> ##2 bidirOe == $past(avsWritedata[7:0], 2))
    else $error("direction not applied");
  a_fixed_out: assert property (wEff && avsAddress == ADDR_OUT_PORT
    |-> ##2 fixedOutputPort == $past(avsWritedata[7:0], 2))
    else $error("fixed output missed");
  a_latch_mask: assert property (plain |-> (bidirOut & ~bidirOe) == 8'h00)
    else $error("input pin driven");
  a_unmapped_zero: assert property (avsRead && !avsWaitrequest
    && avsAddress == 6'h3C |-> avsReaddata == RD_UNMAPPED)
    else $error("unmapped read not zero");
  c_cmd: cover property (cmdW);
  c_read: cover property (avsRead && !avsWaitrequest);
  c_pwm: cover property (pwmSelect);
endmodule

// >>> tb/mppdc_pins.sv
// Model of external switches and loads on the bidirectional pins.
`timescale 1ns/1ps
module mppdc_pins (
  input wire logic [7:0] bidirOut,
  input wire logic [7:0] bidirOe,
  input wire logic [7:0] extLevel,
  output logic     [7:0] bidirIn
);
  // A driven pin shows the device level; a released one shows the switch.
  assign bidirIn = (bidirOut & bidirOe) | (extLevel & ~bidirOe);
endmodule

// >>> tb/mppdc_top_test.sv
// Testbench of the pin block driven over its register bus.
`timescale 1ns/1ps
module mppdc_top_test;
  import mppdc_pkg::*;
  localparam int RF = 8;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [5:0]  avsAddress = 6'h00;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0]  avsByteenable = 4'h1;
  logic [31:0] avsReaddata, d;
  logic        avsWaitrequest, pwmSelect, twoWireTargetCmd;
  logic        irIn, kbdClk, kbdData;
  logic [7:0]  fixedOutputPort, bidirIn, bidirOut, bidirOe;
  logic [7:0]  standardInputPort = 8'h00;
  logic [7:0]  extLevel = 8'h00;
  logic [3:0]  analogCapableIn = 4'h0;
  logic [2:0]  fixedAnalogPort = 3'h0, analogSample;
  logic        pwmA = 1'b0;
  logic        pwmB = 1'b0;
  logic [31:0] sel [5] = '{32'h001, 32'h510, 32'h101, 32'h60A, 32'h205};
  logic [4:0]  tExp = 5'h0B;
  int          badCount = 0;
  int          cmpCount = 0;
  int          cyc = 0;
  always #2 mclk = ~mclk;
  mppdc_top #(.REFRESH(RF)) dut (.mclk, .nrst, .avsAddress, .avsRead,
    .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest,
    .fixedOutputPort, .standardInputPort, .bidirIn, .bidirOut, .bidirOe,
    .analogCapableIn, .fixedAnalogPort, .pwmA, .pwmB, .pwmSelect,
    .twoWireTargetCmd, .analogSample, .irIn, .kbdClk, .kbdData);
  mppdc_pins pins (.bidirOut, .bidirOe, .extLevel, .bidirIn);
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmpCount++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Waits two more edges so registered pins reflect the access.
  task acc(input logic w, input logic [5:0] a, input logic [31:0] v);
    @(posedge mclk);
    avsAddress <= a;
    avsWritedata <= v;
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge mclk); while (avsWaitrequest !== 1'b0);
    d = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task completeRun;
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      badCount++;
      completeRun;
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk(bidirOe, 8'h00);
    acc(0, ADDR_TRIS, 32'h0);
    chk(d[7:0], 8'hFF);
    acc(1, ADDR_DIRS, 32'hFF);
    acc(1, ADDR_PINS, 32'hA5);
    chk(bidirOut, 8'hA5);
    acc(1, ADDR_PORTC_ALIAS, 32'h5A);
    chk(bidirOut, 8'h5A);
    acc(1, ADDR_TRIS, 32'hF0);
    chk(bidirOut, 8'h0A);
    acc(0, ADDR_DIRS, 32'h0);
    chk(d[7:0], 8'h0F);
    $display("direction test done");
    acc(1, ADDR_DIRS, 32'h0);
    acc(1, ADDR_PINS, 32'h0);
    for (int p = 0; p < 8; p++) begin
      acc(1, ADDR_CMD, 32'h100 + 32'(p));
      chk(bidirOe, 8'hFF >> (7 - p));
      chk(bidirOut, 8'h01 << p);
      acc(1, ADDR_CMD, 32'h200 + 32'(p));
      chk(bidirOut, 8'h00);
    end
    $display("command test done");
    standardInputPort <= 8'hC1;
    extLevel <= 8'h96;
    analogCapableIn <= 4'hA;
    fixedAnalogPort <= 3'h5;
    acc(1, ADDR_DIRS, 32'h0F);
    acc(1, ADDR_BIDIR_IN, 32'hFF);
    // The raw poke survives only until the copy is restored.
    repeat (2 * RF) @(posedge mclk);
    chk(bidirOe, 8'h0F);
    acc(0, ADDR_STD_IN, 32'h0);
    chk(d[7:0], 8'hC1);
    chk({5'h0, kbdData, kbdClk, irIn}, 8'h07);
    acc(0, ADDR_BIDIR_IN, 32'h0);
    chk(d[7:0], 8'h90);
    acc(0, ADDR_ANA_IN, 32'h0);
    chk(d[7:0], 8'h0A);
    chk({5'h0, analogSample}, 8'h05);
    for (int i = 0; i < 5; i++) begin
      acc(0, ADDR_TEST, sel[i]);
      chk(d[7:0], {7'h0, tExp[i]});
    end
    acc(0, 6'h3C, 32'h0);
    chk(d[7:0], 8'h00);
    $display("input test done");
    acc(1, ADDR_OUT_PORT, 32'h3C);
    chk(fixedOutputPort, 8'h3C);
    pwmA <= 1'b1;
    acc(1, ADDR_DIRS, 32'hFF);
    acc(1, ADDR_PERIPH, 32'h1);
    chk(bidirOut, 8'h02);
    acc(1, ADDR_PERIPH, 32'h2);
    chk(bidirOe, 8'hE7);
    chk({6'h0, twoWireTargetCmd, pwmSelect}, 8'h02);
    $display("peripheral test done");
    // A reset in mid-run must turn every bidirectional pin into input.
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk(bidirOe, 8'h00);
    chk(fixedOutputPort, 8'h00);
    chk({6'h0, twoWireTargetCmd, pwmSelect}, 8'h00);
    $display("reset test done");
    completeRun;
  end
endmodule
bind mppdc_top mppdc_assertions chkr (.mclk, .nrst, .avsAddress, .avsRead,
  .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest,
  .fixedOutputPort, .bidirOut, .bidirOe, .pwmSelect, .twoWireTargetCmd);
